// [logic/posm_pkg.sv]
/*
  Constants for the pin output source multiplexer: register offsets,
  field positions, reset values and source codes.
  Assumes a plain register port with byte-wide registers.
*/
`default_nettype none
package posm_pkg;
  localparam logic [7:0] POSM_PIN2_OFFSET = 8'h12;  // First pin control register
  localparam logic [7:0] POSM_PIN3_OFFSET = 8'h13;
  localparam logic [7:0] POSM_PIN4_OFFSET = 8'h14;
  localparam int         POSM_NUM_PINS    = 3;      // Pins 2, 3 and 4
  localparam int         POSM_SEL_MSB     = 7;      // Signal select field
  localparam int         POSM_SEL_LSB     = 5;
  localparam int         POSM_SRC_MSB     = 4;      // Source select field
  localparam int         POSM_SRC_LSB     = 2;
  localparam int         POSM_VAL_BIT     = 1;      // Local value bit
  localparam int         POSM_EN_BIT      = 0;      // Drive enable bit
  localparam logic [7:0] POSM_CTL_RESET   = 8'h00;  // All fields reset to zero
  localparam logic [2:0] POSM_SRC_STATUS  = 3'h4;   // Device status group
  localparam logic [2:0] POSM_SRC_RSVD    = 3'h5;
  localparam logic [2:0] POSM_SRC_TX0     = 3'h6;
  localparam logic [2:0] POSM_SRC_TX1     = 3'h7;
endpackage
`default_nettype wire

// [logic/posm_pin_select.sv]
/*
  Combinational selection of one pin's output value from its control
  byte and the shared receive, status and transmit signal groups.
  Assumes all inputs are already on the block clock.
*/
`timescale 1ns/1ps
`default_nettype none
module posm_pin_select
  import posm_pkg::*;
(
  input  wire logic [7:0]  ctl,           // Pin control byte
  input  wire logic [15:0] rx_remote,     // Remote pin values, 4 per port
  input  wire logic [3:0]  rx_lock,       // Per-port lock
  input  wire logic [3:0]  rx_pass,       // Per-port pass
  input  wire logic [3:0]  rx_frame,      // Per-port frame valid
  input  wire logic [3:0]  rx_line,       // Per-port line valid
  input  wire logic [3:0]  rx_enabled,    // Receive ports enabled
  input  wire logic        frame_sync_pulse, // Internal frame sync
  input  wire logic [1:0]  tx_pass_and,   // Per transmit port
  input  wire logic [1:0]  tx_pass_or,
  input  wire logic [1:0]  tx_frame,
  input  wire logic [1:0]  tx_line,
  input  wire logic [1:0]  tx_synced,
  input  wire logic [1:0]  tx_irq,
  output logic             value          // Selected pin value
);
  logic [2:0] src;                        // Source code
  logic [2:0] sel;                        // Signal code
  logic [1:0] port;                       // Receive port index
  logic       txp;                        // Transmit port index
  assign src  = ctl[POSM_SRC_MSB:POSM_SRC_LSB];
  assign sel  = ctl[POSM_SEL_MSB:POSM_SEL_LSB];
  assign port = src[1:0];
  assign txp  = src[0];

  // Two-level decode; reserved corners fall to zero
  always_comb begin
    value = 1'b0;                         // Reserved codes drive low
    if (!src[2]) begin                    // Receive port source
      case (sel)
        3'h0, 3'h1, 3'h2, 3'h3: value = rx_remote[{port, sel[1:0]}];
        3'h4:    value = rx_lock[port];
        3'h5:    value = rx_pass[port];
        3'h6:    value = rx_frame[port];
        3'h7:    value = rx_line[port];
        default: value = 1'b0;
      endcase
    end else if (src == POSM_SRC_STATUS) begin
      case (sel)
        3'h0:    value = ctl[POSM_VAL_BIT];
        // Disabled ports are ignored; none enabled gives OR 0, AND 0
        3'h1:    value = |(rx_lock & rx_enabled);
        3'h2:    value = (|rx_enabled) &&
                         ((rx_lock | ~rx_enabled) == 4'hF);
        3'h3:    value = (|rx_enabled) &&
                         ((rx_pass | ~rx_enabled) == 4'hF);
        3'h4:    value = frame_sync_pulse;
        default: value = 1'b0;
      endcase
    end else if (src == POSM_SRC_TX0 || src == POSM_SRC_TX1) begin
      case (sel)
        3'h0:    value = tx_pass_and[txp];
        3'h1:    value = tx_pass_or[txp];
        3'h2:    value = tx_frame[txp];
        3'h3:    value = tx_line[txp];
        3'h4:    value = tx_synced[txp];
        3'h5:    value = tx_irq[txp];
        default: value = 1'b0;
      endcase
    end else begin
      value = 1'b0;                       // Reserved source
    end
  end
endmodule // posm_pin_select
`default_nettype wire

// [logic/posm_top.sv]
/*
  Output source multiplexer for pins 2, 3 and 4: three control
  registers on a plain register port and registered pin drivers.
  Assumes all status inputs come from logic on the same clock;
  the pins themselves are resolved outside from out and oe.
*/
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module posm_top
  import posm_pkg::*;
(
  input  wire logic        clock,            // 100 MHz block clock
  input  wire logic        rst,              // Async reset, active high
  input  wire logic [7:0]  addr,             // Register address
  input  wire logic [7:0]  wdata,            // Write data
  input  wire logic        wr,               // Write strobe
  input  wire logic        rd,               // Read strobe
  output logic      [7:0]  rdata,            // Read data, cycle after rd
  input  wire logic [15:0] rx_remote,        // Remote pin values
  input  wire logic [3:0]  rx_lock,
  input  wire logic [3:0]  rx_pass,
  input  wire logic [3:0]  rx_frame,
  input  wire logic [3:0]  rx_line,
  input  wire logic [3:0]  rx_enabled,
  input  wire logic        frame_sync_pulse,
  input  wire logic [1:0]  tx_pass_and,
  input  wire logic [1:0]  tx_pass_or,
  input  wire logic [1:0]  tx_frame,
  input  wire logic [1:0]  tx_line,
  input  wire logic [1:0]  tx_synced,
  input  wire logic [1:0]  tx_irq,
  output logic      [2:0]  pin_out,          // Pin values, bit 0 is pin 2
  output logic      [2:0]  pin_oe            // Pin drive enables
);
  logic [7:0] ctl_q [POSM_NUM_PINS];         // Control registers
  logic [7:0] ctl_d [POSM_NUM_PINS];
  logic [7:0] rdata_d;                       // Next read data
  logic [2:0] sel_val;                       // Per-pin selected value
  logic [2:0] out_d;                         // Next pin values
  logic [2:0] oe_d;                          // Next enables

  // Map an address to a pin index; 3 means unmapped
  function automatic logic [1:0] pin_index(input logic [7:0] a);
    case (a)
      POSM_PIN2_OFFSET: pin_index = 2'h0;
      POSM_PIN3_OFFSET: pin_index = 2'h1;
      POSM_PIN4_OFFSET: pin_index = 2'h2;
      default:          pin_index = 2'h3;
    endcase
  endfunction

  // Register writes and read data
  always_comb begin
    for (int i = 0; i < POSM_NUM_PINS; i++) begin
      ctl_d[i] = ctl_q[i];
    end
    if (wr && pin_index(addr) != 2'h3) begin
      ctl_d[pin_index(addr)] = wdata;
    end
    rdata_d = 8'h00;                         // Unmapped reads give zero
    if (rd && pin_index(addr) != 2'h3) begin
      rdata_d = ctl_q[pin_index(addr)];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < POSM_NUM_PINS; i++) begin
        ctl_q[i] <= POSM_CTL_RESET;          // Driver off, value 0
      end
      rdata <= 8'h00;
    end else begin
      for (int i = 0; i < POSM_NUM_PINS; i++) begin
        ctl_q[i] <= ctl_d[i];
      end
      rdata <= rdata_d;
    end
  end

  // One selector per pin; sharing the module keeps decode identical
  for (genvar g = 0; g < POSM_NUM_PINS; g++) begin : g_pin
    posm_pin_select u_sel (
      .ctl              (ctl_q[g]),
      .rx_remote        (rx_remote),
      .rx_lock          (rx_lock),
      .rx_pass          (rx_pass),
      .rx_frame         (rx_frame),
      .rx_line          (rx_line),
      .rx_enabled       (rx_enabled),
      .frame_sync_pulse (frame_sync_pulse),
      .tx_pass_and      (tx_pass_and),
      .tx_pass_or       (tx_pass_or),
      .tx_frame         (tx_frame),
      .tx_line          (tx_line),
      .tx_synced        (tx_synced),
      .tx_irq           (tx_irq),
      .value            (sel_val[g])
    );
  end

  // Pin drivers; a disabled pin also shows value 0 to avoid glitches
  always_comb begin
    for (int i = 0; i < POSM_NUM_PINS; i++) begin
      oe_d[i]  = ctl_q[i][POSM_EN_BIT];
      out_d[i] = ctl_q[i][POSM_EN_BIT] & sel_val[i];
    end
  end

  // Registered outputs cost one cycle of latency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out <= 3'h0;
      pin_oe  <= 3'h0;
    end else begin
      pin_out <= out_d;
      pin_oe  <= oe_d;
    end
  end

  // Enable follows bit 0 two cycles after its write
  a_enable_follows: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == POSM_PIN2_OFFSET) |-> ##2 (pin_oe[0] == $past(wdata[0], 2)))
    else $error("pin 2 enable does not follow bit 0");
  // Local value on status select 0
  a_local_value: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][4:2] == POSM_SRC_STATUS && ctl_q[0][7:5] == 3'h0 && ctl_q[0][0])
      |=> (pin_out[0] == $past(ctl_q[0][1])))
    else $error("pin 2 local value not driven");
  // Reserved source gives low
  a_reserved_low: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[1][4:2] == POSM_SRC_RSVD) |=> !pin_out[1])
    else $error("pin 3 reserved source not low");
  // Disabled pin shows no drive
  a_disabled_off: assert property (@(posedge clock) disable iff (rst)
    !ctl_q[2][0] |=> (!pin_oe[2] && !pin_out[2]))
    else $error("pin 4 disabled but driven");
  // Receive lock selection
  a_rx_lock: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][0] && ctl_q[0][4:2] == 3'h1 && ctl_q[0][7:5] == 3'h4)
      |=> (pin_out[0] == $past(rx_lock[1])))
    else $error("pin 2 lock selection wrong");
  // Remote pin value selection
  a_rx_remote: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][0] && ctl_q[0][4:2] == 3'h2 && ctl_q[0][7:5] == 3'h3)
      |=> (pin_out[0] == $past(rx_remote[11])))
    else $error("pin 2 remote value wrong");
  // Frame sync selection
  a_frame_sync: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[1][0] && ctl_q[1][4:2] == POSM_SRC_STATUS && ctl_q[1][7:5] == 3'h4)
      |=> (pin_out[1] == $past(frame_sync_pulse)))
    else $error("pin 3 frame sync wrong");
  // Transmit interrupt selection
  a_tx_irq: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[2][0] && ctl_q[2][4:2] == POSM_SRC_TX1 && ctl_q[2][7:5] == 3'h5)
      |=> (pin_out[2] == $past(tx_irq[1])))
    else $error("pin 4 transmit interrupt wrong");
  // Read returns the stored byte
  a_read_back: assert property (@(posedge clock) disable iff (rst)
    (rd && addr == POSM_PIN3_OFFSET) |=> (rdata == $past(ctl_q[1])))
    else $error("pin 3 read back wrong");

  // Receive pass selection on pin 3
  a_rx_pass: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[1][0] && ctl_q[1][4:2] == 3'h0 && ctl_q[1][7:5] == 3'h5)
      |=> (pin_out[1] == $past(rx_pass[0])))
    else $error("pin 3 pass selection wrong");

  // Receive frame valid selection on pin 2
  a_rx_frame: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][0] && ctl_q[0][4:2] == 3'h3 && ctl_q[0][7:5] == 3'h6)
      |=> (pin_out[0] == $past(rx_frame[3])))
    else $error("pin 2 frame valid selection wrong");

  // Receive line valid selection on pin 4
  a_rx_line: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[2][0] && ctl_q[2][4:2] == 3'h2 && ctl_q[2][7:5] == 3'h7)
      |=> (pin_out[2] == $past(rx_line[2])))
    else $error("pin 4 line valid selection wrong");

  // Remote pin 0 of port 1 on pin 3
  a_remote_first: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[1][0] && ctl_q[1][4:2] == 3'h1 && ctl_q[1][7:5] == 3'h0)
      |=> (pin_out[1] == $past(rx_remote[4])))
    else $error("pin 3 remote value wrong");

  // Status OR of enabled locks on pin 2
  a_status_or_lock: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][0] && ctl_q[0][4:2] == POSM_SRC_STATUS && ctl_q[0][7:5] == 3'h1)
      |=> (pin_out[0] == ($past(rx_lock & rx_enabled) != 4'h0)))
    else $error("pin 2 lock OR wrong");

  // Status AND of enabled locks on pin 4
  a_status_and_lock: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[2][0] && ctl_q[2][4:2] == POSM_SRC_STATUS && ctl_q[2][7:5] == 3'h2)
      |=> (pin_out[2] == ($past(rx_enabled) != 4'h0 &&
           $past(rx_lock & rx_enabled) == $past(rx_enabled))))
    else $error("pin 4 lock AND wrong");

  // Status AND of enabled pass flags on pin 3
  a_status_and_pass: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[1][0] && ctl_q[1][4:2] == POSM_SRC_STATUS && ctl_q[1][7:5] == 3'h3)
      |=> (pin_out[1] == ($past(rx_enabled) != 4'h0 &&
           $past(rx_pass & rx_enabled) == $past(rx_enabled))))
    else $error("pin 3 pass AND wrong");

  // Reserved status selects stay low on pin 2
  a_status_reserved: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][4:2] == POSM_SRC_STATUS && ctl_q[0][7:5] >= 3'h5)
      |=> !pin_out[0])
    else $error("pin 2 reserved status select not low");

  // Frame sync on pin 2
  a_fsync_pin2: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][0] && ctl_q[0][4:2] == POSM_SRC_STATUS && ctl_q[0][7:5] == 3'h4)
      |=> (pin_out[0] == $past(frame_sync_pulse)))
    else $error("pin 2 frame sync wrong");

  // Local value on pin 3
  a_local_pin3: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[1][0] && ctl_q[1][4:2] == POSM_SRC_STATUS && ctl_q[1][7:5] == 3'h0)
      |=> (pin_out[1] == $past(ctl_q[1][1])))
    else $error("pin 3 local value not driven");

  // Local value on pin 4
  a_local_pin4: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[2][0] && ctl_q[2][4:2] == POSM_SRC_STATUS && ctl_q[2][7:5] == 3'h0)
      |=> (pin_out[2] == $past(ctl_q[2][1])))
    else $error("pin 4 local value not driven");

  // Transmit port 0 pass AND on pin 3
  a_tx_pass_and: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[1][0] && ctl_q[1][4:2] == POSM_SRC_TX0 && ctl_q[1][7:5] == 3'h0)
      |=> (pin_out[1] == $past(tx_pass_and[0])))
    else $error("pin 3 transmit pass AND wrong");

  // Transmit port 1 pass OR on pin 2
  a_tx_pass_or: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][0] && ctl_q[0][4:2] == POSM_SRC_TX1 && ctl_q[0][7:5] == 3'h1)
      |=> (pin_out[0] == $past(tx_pass_or[1])))
    else $error("pin 2 transmit pass OR wrong");

  // Transmit port 0 frame active on pin 4
  a_tx_frame: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[2][0] && ctl_q[2][4:2] == POSM_SRC_TX0 && ctl_q[2][7:5] == 3'h2)
      |=> (pin_out[2] == $past(tx_frame[0])))
    else $error("pin 4 transmit frame wrong");

  // Transmit port 1 line active on pin 3
  a_tx_line: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[1][0] && ctl_q[1][4:2] == POSM_SRC_TX1 && ctl_q[1][7:5] == 3'h3)
      |=> (pin_out[1] == $past(tx_line[1])))
    else $error("pin 3 transmit line wrong");

  // Transmit port 0 synchronized on pin 2
  a_tx_synced: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[0][0] && ctl_q[0][4:2] == POSM_SRC_TX0 && ctl_q[0][7:5] == 3'h4)
      |=> (pin_out[0] == $past(tx_synced[0])))
    else $error("pin 2 transmit synchronized wrong");

  // Reserved transmit selects stay low on pin 4
  a_tx_reserved: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[2][4:3] == 2'h3 && ctl_q[2][7:6] == 2'h3)
      |=> !pin_out[2])
    else $error("pin 4 reserved transmit select not low");

  // Reserved source stays low on pin 4
  a_src_reserved: assert property (@(posedge clock) disable iff (rst)
    (ctl_q[2][4:2] == POSM_SRC_RSVD) |=> !pin_out[2])
    else $error("pin 4 reserved source not low");

  // A mapped write lands whole
  a_write_lands: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == POSM_PIN4_OFFSET) |=> (ctl_q[2] == $past(wdata)))
    else $error("pin 4 write did not land");

  // An unmapped write leaves every register alone
  a_unmapped_write: assert property (@(posedge clock) disable iff (rst)
    (wr && pin_index(addr) == 2'h3)
      |=> ($stable(ctl_q[0]) && $stable(ctl_q[1]) && $stable(ctl_q[2])))
    else $error("unmapped write changed a register");

  // An unmapped read returns zero
  a_unmapped_read: assert property (@(posedge clock) disable iff (rst)
    (rd && pin_index(addr) == 2'h3) |=> (rdata == 8'h00))
    else $error("unmapped read not zero");

  // Read data stand one cycle only
  a_rdata_idle: assert property (@(posedge clock) disable iff (rst)
    !rd |=> (rdata == 8'h00))
    else $error("read data outside read cycle");

  // Each drive enable follows its bit 0 one cycle later
  a_oe_pin2: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (pin_oe[0] == $past(ctl_q[0][0])))
    else $error("pin 2 enable does not follow register");

  a_oe_pin3: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (pin_oe[1] == $past(ctl_q[1][0])))
    else $error("pin 3 enable does not follow register");

  a_oe_pin4: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (pin_oe[2] == $past(ctl_q[2][0])))
    else $error("pin 4 enable does not follow register");

  // Disabled pin 2 shows low
  a_disabled_pin2: assert property (@(posedge clock) disable iff (rst)
    !ctl_q[0][0] |=> !pin_out[0])
    else $error("pin 2 disabled but high");
endmodule // posm_top
`default_nettype wire

// [sim/posm_pin_load.sv]
/*
  Board-side load on pins 2, 3 and 4: a weak pull-down on each pin.
  Assumes the block drives a pin only while its enable is high.
*/
`timescale 1ns/1ps
`default_nettype none
module posm_pin_load (
  input  wire logic [2:0] pin_out,  // Values offered by the block
  input  wire logic [2:0] pin_oe,   // High while the block drives
  output logic      [2:0] level     // Resolved pin levels
);
  // Undriven pins fall to the pull-down, never keep the last value
  assign level = pin_oe & pin_out;
endmodule // posm_pin_load
`default_nettype wire

// [sim/pin_output_source_mux_bench.sv]
/*
  Bench for posm_top: register port tasks, reset and unmapped checks,
  then a sweep of all 256 control bytes against a pin model.
  Assumes a 100 MHz clock and the pull-down load model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_errors++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, gt); end end
module pin_output_source_mux_bench;
  import posm_pkg::*;
  logic        clock, rst, wr, rd;          // Clock, reset, strobes
  logic [7:0]  addr, wdata, rdata;          // Register port
  logic [15:0] rx_remote;                   // Remote pin values
  logic [3:0]  rx_lock, rx_pass, rx_frame, rx_line, rx_enabled;
  logic        frame_sync_pulse;
  logic [1:0]  tx_pass_and, tx_pass_or, tx_frame, tx_line, tx_synced, tx_irq;
  logic [2:0]  pin_out, pin_oe, level;      // Pins and resolved levels
  logic [63:0] pat = 64'h0123_4567_89AB_CDEF; // Stimulus pattern
  int          n_errors = 0;
  int          samples_checked = 0;

  posm_top posm_top_inst (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_remote,
    .rx_lock, .rx_pass, .rx_frame, .rx_line, .rx_enabled, .frame_sync_pulse,
    .tx_pass_and, .tx_pass_or, .tx_frame, .tx_line, .tx_synced, .tx_irq,
    .pin_out, .pin_oe);
  posm_pin_load posm_pin_load_inst (.pin_out, .pin_oe, .level);

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Status inputs from slices of the pattern
  task automatic drive_inputs();
    {rx_remote, rx_lock, rx_pass, rx_frame, rx_line} <= pat[31:0];
    {rx_enabled, frame_sync_pulse, tx_pass_and, tx_pass_or} <= pat[40:32];
    {tx_frame, tx_line, tx_synced, tx_irq} <= pat[48:41];
  endtask

  // Expected pin value, worked out from the control byte and the current status inputs
  function automatic logic exp_pin(input logic [7:0] c);
    logic [1:0] p;
    logic [7:0] v;
    p = c[3:2];
    if (!c[0]) return 1'b0;
    if (!c[4]) v = {rx_line[p], rx_frame[p], rx_pass[p], rx_lock[p], rx_remote[{p, 2'h0} +: 4]};
    else if (p == 2'h0) v = {3'h0, frame_sync_pulse,
      &(rx_pass | ~rx_enabled) & |rx_enabled, &(rx_lock | ~rx_enabled) & |rx_enabled,
      |(rx_lock & rx_enabled), c[1]};
    else if (p == 2'h1) v = 8'h00;      // Reserved source reads low
    else v = {2'h0, tx_irq[c[2]], tx_synced[c[2]], tx_line[c[2]], tx_frame[c[2]],
      tx_pass_or[c[2]], tx_pass_and[c[2]]};
    return v[c[7:5]];
  endfunction

  // One-cycle write; called at a rising edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // One-cycle read; data checked in the following cycle only
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] ex);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 `CHK("rdata", ex, rdata)
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well beyond the roughly 790 cycles of the tests
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    {wr, rd, addr, wdata} = '0;
    {rx_remote, rx_lock, rx_pass, rx_frame, rx_line, rx_enabled} = '0;
    {frame_sync_pulse, tx_pass_and, tx_pass_or, tx_frame, tx_line, tx_synced, tx_irq} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // Reset values; the fourth address is unmapped and reads zero
    for (int i = 0; i < 4; i++) begin
      reg_rd(POSM_PIN2_OFFSET + 8'(i), 8'h00);
      `CHK("pin_oe", 3'h0, pin_oe)
      @(posedge clock);
    end
    // Unmapped write must not land; read follows with no gap
    reg_wr(8'h11, 8'hFF);
    reg_rd(POSM_PIN2_OFFSET, 8'h00);
    $display("test reset and unmapped done");
    @(posedge clock);
    // Every control byte, rotated over the three pins
    for (int c = 0; c < 256; c++) begin
      pat = pat * 64'h5851_F42D_4C95_7F2D + 64'h1405_7B7E_F767_814F;
      drive_inputs();
      reg_wr(POSM_PIN2_OFFSET + 8'(c % 3), 8'(c));
      reg_rd(POSM_PIN2_OFFSET + 8'(c % 3), 8'(c));
      `CHK("pin_out", exp_pin(8'(c)), pin_out[c % 3])
      `CHK("pin_src", exp_pin(8'(c)), level[c % 3])
      `CHK("pin_oe", 1'(c), pin_oe[c % 3])
      @(posedge clock);
    end
    $display("test source sweep done");
    // Local value high on pin 2, which the sweep never gives it
    reg_wr(POSM_PIN2_OFFSET, 8'h13);
    @(posedge clock);
    #1 `CHK("pin_out", 1'b1, pin_out[0])
    @(posedge clock);
    $display("test local value done");
    conclude();
  end
endmodule // pin_output_source_mux_bench
`undef CHK
`default_nettype wire
